// ### ued_pkg.sv
// ****************************************************************
// shared constants and types for the endpoint dma port
// ****************************************************************
package ued_pkg;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int unsigned DATA_W      = 8;        // parallel bus width
  localparam int unsigned FIFO_DEPTH  = 16;       // staging fifo words
  localparam int unsigned CNT_W       = 8;        // byte and burst counters
  localparam logic [7:0]  PKT_BULK    = 8'h40;    // 64 byte main buffer
  localparam logic [7:0]  PKT_ISO_ONE = 8'h80;    // 128 byte one-way iso buffer
  localparam logic [1:0]  BUF_COUNT   = 2'h2;     // double buffered endpoint
  localparam logic [1:0]  MAIN_EP     = 2'h2;     // only dma-capable endpoint
  localparam logic [7:0]  BURST_ONE   = 8'h01;    // last beat of a burst
  localparam int unsigned FRAME_US    = 1000;     // usb frame, 1 ms
  localparam int unsigned CLK_KHZ     = 10000;    // ref_clk rate
  localparam int unsigned FRAME_CYC   = FRAME_US * CLK_KHZ / 1000;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic              is_cmd;    // command instruction, else data phase
    logic              is_write;  // write strobe access, else read
    logic [DATA_W-1:0] wdata;     // write byte, zero on reads
  } ued_io_req_t;

  typedef struct packed {
    logic              last;      // final byte of a packet
    logic [DATA_W-1:0] data;      // payload byte
  } ued_word_t;

  localparam int unsigned WORD_W = DATA_W + 1;

  // dma request sequencer
  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_REQ,
    DMA_GAP
  } ued_dma_state_t;

endpackage

// ### ued_dma_port.sv
`timescale 1ns/10ps

// ****************************************************************
// staging fifo, width and depth set by parameters
// ****************************************************************
module ued_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ext_reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];    // storage words
  logic [AW-1:0] wr_ptr_r;      // next write slot
  logic [AW-1:0] rd_ptr_r;      // next read slot
  logic [AW:0]   count_r;       // words held
  logic          push;          // accepted write
  logic          pop;           // accepted read

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      // simultaneous push and pop leaves level unchanged
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ****************************************************************
// parallel host port and dma handshake for the main endpoint
// ****************************************************************
module ued_dma_port #(
  parameter int unsigned DEPTH = ued_pkg::FIFO_DEPTH
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        ext_reset_n,
  input  wire logic                        ale,
  input  wire logic                        cs_n,
  input  wire logic                        rd_n,
  input  wire logic                        wr_n,
  input  wire logic                        cmd_data_select,
  input  wire logic [ued_pkg::DATA_W-1:0]  data_in,
  output logic      [ued_pkg::DATA_W-1:0]  data_out,
  output logic                             data_oe,
  output logic                             dma_request_out,
  input  wire logic                        dma_grant_n,
  input  wire logic                        transfer_end_n,
  input  wire logic                        dma_enable,
  input  wire logic                        dma_dir_read,
  input  wire logic                        dual_addr_mode,
  input  wire logic                        burst_mode,
  input  wire logic [ued_pkg::CNT_W-1:0]   burst_len,
  input  wire logic                        iso_one_way,
  output logic                             io_req_valid,
  output ued_pkg::ued_io_req_t             io_req,
  input  wire logic [ued_pkg::DATA_W-1:0]  io_rdata,
  input  wire logic                        rx_buf_full,
  input  wire logic                        rx_valid,
  output logic                             rx_ready,
  input  wire ued_pkg::ued_word_t          rx_word,
  output logic                             tx_valid,
  input  wire logic                        tx_ready,
  output ued_pkg::ued_word_t               tx_word,
  input  wire logic                        tx_sent_ok,
  output logic                             dma_done,
  output logic [1:0]                       dma_endpoint
);

  // ****************************************************************
  // strobe tracking and access decode
  // ****************************************************************
  logic rd_n_prev_r;           // read strobe one cycle ago
  logic wr_n_prev_r;           // write strobe one cycle ago
  logic ale_prev_r;            // latch strobe one cycle ago
  logic mux_bus_r;             // latch strobe seen active: multiplexed bus
  logic addr_bit_r;            // address bit caught from data lines
  logic dma_acc_r;             // current access belongs to dma
  logic eot_seen_r;            // end-of-transfer seen during access
  logic [ued_pkg::DATA_W-1:0] wdata_r;  // last sampled write byte
  logic is_cmd;                // decoded command/data selection
  logic dma_sel;               // grant honoured this cycle
  logic io_sel;                // ordinary chip select access
  logic rd_fall;               // read strobe start
  logic rd_rise;               // read strobe end
  logic wr_rise;               // write strobe end
  logic dma_rd_done;           // dma read byte completed
  logic dma_wr_done;           // dma write byte completed
  logic dma_xfer;              // any dma byte completed
  logic eot_now;               // valid end-of-transfer condition

  // address bit: from latch in multiplexed mode, else from pin
  assign is_cmd = mux_bus_r ? addr_bit_r : cmd_data_select;
  // grant overrides the endpoint selected for plain io
  assign dma_sel = !dma_grant_n && !dual_addr_mode;
  assign io_sel  = !cs_n && !dma_sel;
  assign rd_fall = !rd_n && rd_n_prev_r;
  assign rd_rise = rd_n && !rd_n_prev_r;
  assign wr_rise = wr_n && !wr_n_prev_r;
  assign dma_rd_done = rd_rise && dma_acc_r;
  assign dma_wr_done = wr_rise && dma_acc_r;
  assign dma_xfer    = dma_rd_done || dma_wr_done;
  // end notice counts only with grant and a strobe
  assign eot_now = !transfer_end_n && dma_sel && (!rd_n || !wr_n);
  // dma path always addresses the main endpoint
  assign dma_endpoint = ued_pkg::MAIN_EP;

  // strobe history
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      rd_n_prev_r <= 1'b1;
      wr_n_prev_r <= 1'b1;
      ale_prev_r  <= 1'b0;
    end else if (rst) begin
      rd_n_prev_r <= 1'b1;
      wr_n_prev_r <= 1'b1;
      ale_prev_r  <= 1'b0;
    end else begin
      rd_n_prev_r <= rd_n;
      wr_n_prev_r <= wr_n;
      ale_prev_r  <= ale;
    end
  end

  // bus style and address latch
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      mux_bus_r  <= 1'b0;
      addr_bit_r <= 1'b1;
    end else if (rst) begin
      mux_bus_r  <= 1'b0;
      addr_bit_r <= 1'b1;
    end else begin
      // any latch pulse marks a multiplexed bus
      if (ale) begin
        mux_bus_r <= 1'b1;
      end
      // close latch on falling edge; a low strobe latches nothing
      if (ale_prev_r && !ale) begin
        addr_bit_r <= data_in[0];
      end
    end
  end

  // access ownership, write byte and end notice
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      dma_acc_r  <= 1'b0;
      eot_seen_r <= 1'b0;
      wdata_r    <= '0;
    end else if (rst) begin
      dma_acc_r  <= 1'b0;
      eot_seen_r <= 1'b0;
      wdata_r    <= '0;
    end else begin
      // owner follows grant while strobe low, held one cycle past strobe end
      if (!rd_n || !wr_n) begin
        dma_acc_r <= dma_sel;
      end else if (!rd_n_prev_r || !wr_n_prev_r) begin
        dma_acc_r <= dma_acc_r;
      end else begin
        dma_acc_r <= 1'b0;
      end
      // end notice sticks until the byte completes
      if (eot_now) begin
        eot_seen_r <= 1'b1;
      end else if (rd_n && wr_n) begin
        eot_seen_r <= 1'b0;
      end
      // track write data while strobe low
      if (!wr_n) begin
        wdata_r <= data_in;
      end
    end
  end

  // ****************************************************************
  // ordinary io requests toward the endpoint logic
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      io_req_valid <= 1'b0;
      io_req       <= '0;
    end else if (rst) begin
      io_req_valid <= 1'b0;
      io_req       <= '0;
    end else begin
      io_req_valid <= 1'b0;
      // read announced at strobe start so data can follow
      if (rd_fall && io_sel) begin
        io_req_valid    <= 1'b1;
        io_req.is_cmd   <= is_cmd;
        io_req.is_write <= 1'b0;
        io_req.wdata    <= '0;
      end else if (wr_rise && !dma_acc_r && !cs_n) begin
        // write committed at strobe end, byte wide
        io_req_valid    <= 1'b1;
        io_req.is_cmd   <= is_cmd;
        io_req.is_write <= 1'b1;
        io_req.wdata    <= wdata_r;
      end
    end
  end

  // ****************************************************************
  // staging fifo between bus and endpoint buffers
  // ****************************************************************
  logic               f_in_valid;   // fifo write request
  logic               f_in_ready;   // fifo has room
  ued_pkg::ued_word_t f_in_word;    // fifo write word
  logic               f_out_valid;  // fifo holds a word
  logic               f_out_ready;  // fifo read request
  ued_pkg::ued_word_t f_out_word;   // fifo head word
  logic               wr_last;      // dma write byte closes a packet
  logic [7:0]         pkt_max;      // buffer size for this mode
  logic [ued_pkg::CNT_W-1:0] wr_cnt_r;   // bytes in open transmit buffer
  logic [1:0]         tx_pend_r;    // filled buffers awaiting ack

  assign pkt_max = iso_one_way ? ued_pkg::PKT_ISO_ONE : ued_pkg::PKT_BULK;
  // packet closes when full, or early on end notice
  assign wr_last = (wr_cnt_r == pkt_max - 8'h01) || eot_seen_r;

  // read toward memory: usb side fills, dma drains
  // write toward host: dma fills, usb side drains
  assign f_in_valid  = dma_dir_read ? rx_valid : dma_wr_done;
  assign f_in_word   = dma_dir_read ? rx_word
                                    : ued_pkg::ued_word_t'{last: wr_last, data: wdata_r};
  assign rx_ready    = dma_dir_read && f_in_ready;
  assign f_out_ready = dma_dir_read ? dma_rd_done : tx_ready;
  assign tx_valid    = !dma_dir_read && f_out_valid;
  assign tx_word     = f_out_word;

  ued_fifo #(
    .W     (ued_pkg::WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .ext_reset_n (ext_reset_n),
    .in_valid    (f_in_valid),
    .in_ready    (f_in_ready),
    .in_data     (f_in_word),
    .out_valid   (f_out_valid),
    .out_ready   (f_out_ready),
    .out_data    (f_out_word)
  );

  // transmit byte count and buffer accounting
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      wr_cnt_r  <= '0;
      tx_pend_r <= '0;
    end else if (rst) begin
      wr_cnt_r  <= '0;
      tx_pend_r <= '0;
    end else begin
      if (dma_wr_done && !dma_dir_read) begin
        wr_cnt_r <= wr_last ? '0 : wr_cnt_r + 1'b1;
      end
      // filled buffer counted up, successful send counts down
      if (dma_wr_done && !dma_dir_read && wr_last && !tx_sent_ok) begin
        tx_pend_r <= tx_pend_r + 1'b1;
      end else if (tx_sent_ok && !(dma_wr_done && wr_last) && tx_pend_r != '0) begin
        tx_pend_r <= tx_pend_r - 1'b1;
      end
    end
  end

  // ****************************************************************
  // dma run control and request sequencer
  // ****************************************************************
  ued_pkg::ued_dma_state_t state_r;       // sequencer state
  logic                    run_r;         // dma session active
  logic                    en_prev_r;     // enable one cycle ago
  logic [ued_pkg::CNT_W-1:0] burst_cnt_r; // beats left in burst
  logic                    req_ok;        // data side can take or supply a byte
  logic                    short_end;     // read popped a packet's last byte
  logic                    burst_end;     // burst count spent
  logic                    stop_now;      // end notice at byte end
  logic [ued_pkg::CNT_W-1:0] burst_load;  // reload value, zero as one

  assign burst_load = (burst_len == '0) ? ued_pkg::BURST_ONE : burst_len;
  assign short_end  = dma_rd_done && f_out_word.last;
  assign burst_end  = burst_cnt_r == ued_pkg::BURST_ONE;
  assign stop_now   = dma_xfer && eot_seen_r;
  // read needs a full buffer; write needs room and a free buffer
  assign req_ok = run_r && !dual_addr_mode &&
                  (dma_dir_read ? (rx_buf_full && f_out_valid)
                                : (f_in_ready && tx_pend_r < ued_pkg::BUF_COUNT));

  // session: starts on enable, ends on end notice or clear
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      run_r     <= 1'b0;
      en_prev_r <= 1'b0;
      dma_done  <= 1'b0;
    end else if (rst) begin
      run_r     <= 1'b0;
      en_prev_r <= 1'b0;
      dma_done  <= 1'b0;
    end else begin
      en_prev_r <= dma_enable;
      dma_done  <= 1'b0;
      if (!dma_enable) begin
        run_r    <= 1'b0;
        dma_done <= run_r;
      end else if (stop_now && run_r) begin
        run_r    <= 1'b0;
        dma_done <= 1'b1;
      end else if (!en_prev_r) begin
        run_r <= 1'b1;
      end
    end
  end

  // request sequencer and burst counter
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      state_r     <= ued_pkg::DMA_IDLE;
      burst_cnt_r <= ued_pkg::BURST_ONE;
    end else if (rst) begin
      state_r     <= ued_pkg::DMA_IDLE;
      burst_cnt_r <= ued_pkg::BURST_ONE;
    end else begin
      case (state_r)
        ued_pkg::DMA_IDLE: begin
          burst_cnt_r <= burst_load;
          if (run_r) begin
            state_r <= ued_pkg::DMA_REQ;
          end
        end
        ued_pkg::DMA_REQ: begin
          if (!run_r || stop_now) begin
            state_r <= ued_pkg::DMA_IDLE;
          end else if (dma_xfer) begin
            if (!burst_mode) begin
              state_r <= ued_pkg::DMA_GAP;
            end else if (short_end || burst_end) begin
              state_r     <= ued_pkg::DMA_GAP;
              burst_cnt_r <= burst_load;
            end else begin
              burst_cnt_r <= burst_cnt_r - 1'b1;
            end
          end
        end
        ued_pkg::DMA_GAP: begin
          // release until grant is withdrawn
          if (!run_r) begin
            state_r <= ued_pkg::DMA_IDLE;
          end else if (dma_grant_n) begin
            state_r <= ued_pkg::DMA_REQ;
          end
        end
        default: begin
          state_r <= ued_pkg::DMA_IDLE;
        end
      endcase
    end
  end

  // request pin, dropped the cycle after a single-mode byte or a burst's last byte completes
  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      dma_request_out <= 1'b0;
    end else if (rst) begin
      dma_request_out <= 1'b0;
    end else begin
      dma_request_out <= (state_r == ued_pkg::DMA_REQ) && req_ok &&
                         !(dma_xfer && (!burst_mode || short_end || burst_end)) &&
                         !stop_now;
    end
  end

  // ****************************************************************
  // read data return and pin drive
  // ****************************************************************
  // drive only while a read strobe is qualified
  assign data_oe = (!cs_n || dma_sel) && !rd_n;

  always_ff @(posedge ref_clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      data_out <= '0;
    end else if (rst) begin
      data_out <= '0;
    end else begin
      if (!rd_n && dma_sel) begin
        data_out <= f_out_word.data;
      end else if (!rd_n && io_sel) begin
        data_out <= io_rdata;
      end
    end
  end

endmodule

// ### ued_dma_port_asserts.sv
`timescale 1ns/10ps
// ****
// pin checks
// ****
module ued_dma_port_asserts #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       ext_reset_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic [7:0] io_rdata,
  input wire logic       io_req_valid,
  input wire ued_pkg::ued_io_req_t io_req,
  input wire logic       dma_request_out,
  input wire logic       dma_grant_n,
  input wire logic       transfer_end_n,
  input wire logic       dma_enable,
  input wire logic       dma_dir_read,
  input wire logic       dual_addr_mode,
  input wire logic       burst_mode,
  input wire logic       rx_buf_full,
  input wire logic       dma_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !ext_reset_n);
  bus_drive_a: assert property (data_oe == (!rd_n && (!cs_n || (!dma_grant_n &&
    !dual_addr_mode)))) else $error("bus drive wrong");
  io_write_a: assert property ($rose(wr_n) && !$past(cs_n) && dma_grant_n |=> io_req_valid
    && io_req.is_write && io_req.wdata == $past(data_in, 2)) else $error("write lost");
  io_read_a: assert property ($fell(rd_n) && !cs_n && dma_grant_n |=> io_req_valid
    && !io_req.is_write) else $error("read lost");
  read_data_a: assert property (!cs_n && !rd_n && dma_grant_n && $past(!cs_n && !rd_n)
    |-> data_out == $past(io_rdata)) else $error("read data stale");
  req_enable_a: assert property (!dma_enable && !$past(dma_enable) && !$past(dma_enable, 2)
    |-> !dma_request_out) else $error("request while off");
  dual_quiet_a: assert property (dual_addr_mode && $past(dual_addr_mode, 2)
    |-> !dma_request_out) else $error("request in dual mode");
  rx_full_a: assert property ($rose(dma_request_out) && dma_dir_read |-> $past(rx_buf_full))
    else $error("read request early");
  single_drop_a: assert property (!burst_mode && !dma_grant_n && ($rose(rd_n) || $rose(wr_n))
    |-> ##[1:2] !dma_request_out) else $error("request held");
  end_done_a: assert property (dma_enable && !dual_addr_mode && !transfer_end_n && !dma_grant_n
    && ($rose(rd_n) || $rose(wr_n)) |-> ##[1:2] dma_done) else $error("no done");
  cover property (io_req_valid && io_req.is_cmd);
  cover property (dma_done);
  cover property ($fell(dma_request_out) && burst_mode);
endmodule
bind ued_dma_port ued_dma_port_asserts #(.DEPTH(DEPTH)) u_chk (.ref_clk, .rst, .ext_reset_n,
  .cs_n, .rd_n, .wr_n, .data_in, .data_out, .data_oe, .io_rdata, .io_req_valid, .io_req,
  .dma_request_out, .dma_grant_n, .transfer_end_n, .dma_enable, .dma_dir_read,
  .dual_addr_mode, .burst_mode, .rx_buf_full, .dma_done);

// ### ued_dmac_model.sv
`timescale 1ns/10ps
// ****
// single-address dma controller
// ****
module ued_dmac_model (
  input wire logic       ref_clk,
  input wire logic       clr,
  input wire logic       dma_request_out,
  input wire logic       dir_read,
  input wire logic [7:0] data_out,
  input wire logic [7:0] end_at,
  output logic           dma_grant_n,
  output logic           rd_n,
  output logic           wr_n,
  output logic           transfer_end_n,
  output logic [7:0]     data_in,
  output logic [7:0]     count,
  output logic [7:0]     rlog [0:31]
);
  logic [1:0] ph;  // byte phase
  initial begin
    {dma_grant_n, rd_n, wr_n, transfer_end_n, data_in, count, ph} = 22'h3c0000;
  end
  // grant with strobe, release strobe one edge later, then grant
  always @(negedge ref_clk) begin
    case (ph)
      2'h0: begin
        data_in <= ~data_in;  // idle bus never holds its value
        if (clr) count <= 8'h00;
        else if (dma_request_out) begin
          {dma_grant_n, rd_n, wr_n, ph} <= {1'b0, !dir_read, dir_read, 2'h1};
          transfer_end_n <= (count + 8'h01 != end_at);
          data_in <= 8'ha0 + count;
        end
      end
      2'h1: begin
        {rd_n, wr_n, ph} <= 4'he;
        if (dir_read) rlog[count[4:0]] <= data_out;
      end
      default: begin
        {dma_grant_n, transfer_end_n, ph} <= 4'hc;
        count <= count + 8'h01;
      end
    endcase
  end
endmodule

// ### tb.sv
`timescale 1ns/10ps
// ****
// scenario bench
// ****
module tb;
  logic       ref_clk, rst, ext_reset_n, ale, cs_n, tb_rd_n, tb_wr_n, m_rd_n, m_wr_n, rd_n;
  logic       wr_n, cmd_data_select, data_oe, dma_request_out, dma_grant_n, transfer_end_n;
  logic       dma_enable, dma_dir_read, dual_addr_mode, burst_mode, iso_one_way, io_req_valid;
  logic       rx_buf_full, rx_valid, rx_ready, tx_valid, tx_ready, tx_sent_ok, dma_done, clr;
  logic [7:0] tb_data, m_data, data_in, data_out, io_rdata, end_at, m_count, burst_len;
  logic [7:0] rlog [0:31];
  ued_pkg::ued_io_req_t io_req;
  ued_pkg::ued_word_t   rx_word, tx_word;
  int         errors = 0, comparisons = 0, dones = 0;
  assign rd_n = tb_rd_n & m_rd_n;
  assign wr_n = tb_wr_n & m_wr_n;
  assign data_in = dma_grant_n ? tb_data : m_data;
  ued_dma_port #(.DEPTH(16)) dut (.ref_clk, .rst, .ext_reset_n, .ale, .cs_n, .rd_n, .wr_n,
    .cmd_data_select, .data_in, .data_out, .data_oe, .dma_request_out, .dma_grant_n,
    .transfer_end_n, .dma_enable, .dma_dir_read, .dual_addr_mode, .burst_mode, .burst_len,
    .iso_one_way, .io_req_valid, .io_req, .io_rdata, .rx_buf_full, .rx_valid, .rx_ready,
    .rx_word, .tx_valid, .tx_ready, .tx_word, .tx_sent_ok, .dma_done, .dma_endpoint());
  ued_dmac_model u_dmac (.ref_clk, .clr, .dma_request_out, .dir_read(dma_dir_read), .data_out,
    .end_at, .dma_grant_n, .rd_n(m_rd_n), .wr_n(m_wr_n), .transfer_end_n, .data_in(m_data),
    .count(m_count), .rlog);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (dma_done === 1'b1) dones++;
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic io_wr(input logic cmd, input logic exp_cmd, input logic [7:0] d);
    @(negedge ref_clk);
    {cmd_data_select, tb_data, cs_n, tb_wr_n} = {cmd, d, 2'b00};
    @(negedge ref_clk);
    tb_wr_n = 1;
    @(negedge ref_clk);
    check({io_req_valid, io_req}, {1'b1, exp_cmd, 1'b1, d});
    cs_n = 1;
  endtask
  task automatic t_io;
    io_wr(1'b1, 1'b1, 8'hd5);
    io_wr(1'b0, 1'b0, 8'h2a);
    @(negedge ref_clk);
    {cmd_data_select, io_rdata, cs_n, tb_rd_n} = {1'b1, 8'h5a, 2'b00};
    @(negedge ref_clk);
    check(data_oe, 1'b1);
    check({io_req_valid, io_req.is_cmd, io_req.is_write, data_out}, 11'h65a);
    io_rdata = 8'h3c;
    @(negedge ref_clk);
    {cs_n, tb_rd_n} = 2'b11;
    @(negedge ref_clk);
    check({data_oe, data_out}, 9'h03c);
  endtask
  task automatic t_dma_read(input logic bm);
    {clr, burst_mode, dma_dir_read, dma_enable} = {1'b1, bm, 2'b11};
    @(negedge ref_clk);
    clr = 0;
    for (int i = 0; i < 5; i++) begin
      {rx_valid, rx_word} = {1'b1, i == 2 || i == 4, 8'(8'h30 + i)};
      while (rx_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
    end
    rx_valid = 0;
    repeat (3) @(negedge ref_clk);
    check({dma_request_out, m_count}, 9'h000);
    rx_buf_full = 1;
    for (int k = 0; k < 300 && m_count != 8'h05; k++) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    check({dma_request_out, m_count}, 9'h005);
    for (int i = 0; i < 5; i++) check(rlog[i], 8'(8'h30 + i));
    {rx_buf_full, dma_enable} = 2'b00;
    @(negedge ref_clk);
    check(dma_done, 1'b1);
  endtask
  task automatic t_dual;
    {dual_addr_mode, dma_dir_read, dma_enable, clr} = 4'hb;
    repeat (8) @(negedge ref_clk);
    check({dma_request_out, m_count}, 9'h000);
    io_wr(1'b0, 1'b0, 8'h5c);
    {dual_addr_mode, dma_enable} = 2'b00;
    @(negedge ref_clk);
    check(dma_done, 1'b1);
  endtask
  task automatic t_dma_write;
    {end_at, clr} = 9'h029;
    @(negedge ref_clk);
    {clr, dma_dir_read, burst_mode, tx_ready, dma_enable, dones} = 37'h100000000;
    for (int k = 0; k < 300 && m_count != 8'h10; k++) @(negedge ref_clk);
    repeat (6) @(negedge ref_clk);
    check({dma_request_out, m_count}, 9'h010);
    tx_ready = 1;
    for (int j = 0; j < 20; j++) begin
      for (int k = 0; k < 50 && tx_valid !== 1'b1; k++) @(negedge ref_clk);
      check(tx_word, {j == 19, 8'(8'ha0 + j)});
      @(negedge ref_clk);
    end
    check(11'(dones), 11'h001);
    dma_enable = 0;
  endtask
  task automatic t_mux;
    @(negedge ref_clk);
    {ale, tb_data} = 9'h101;
    @(negedge ref_clk);
    ale = 0;
    io_wr(1'b0, 1'b1, 8'h77);
  endtask
  initial begin
    ref_clk = 0;
    {rst, ext_reset_n, ale, cs_n, tb_rd_n, tb_wr_n, cmd_data_select} = 7'h6e;
    {dma_enable, dma_dir_read, dual_addr_mode, burst_mode, iso_one_way} = 5'h00;
    {rx_buf_full, rx_valid, tx_ready, tx_sent_ok, clr, rx_word} = 14'h0200;
    {tb_data, io_rdata, end_at, burst_len} = 32'h00000004;
    repeat (2) @(negedge ref_clk);
    rst = 0;
    @(negedge ref_clk);
    check({dma_request_out, io_req_valid, dma_done, data_out}, 11'h000);
    t_io();
    t_dma_read(1'b0);
    t_dma_read(1'b1);
    t_dual();
    t_dma_write();
    @(negedge ref_clk);
    ext_reset_n = 0;
    #10 check({dma_request_out, io_req_valid, dma_done, data_out}, 11'h000);
    @(negedge ref_clk);
    ext_reset_n = 1;
    t_mux();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
endmodule
